/* verilog/lcdgeo_pkg.sv */
// lcdgeo_pkg: register map, field positions, reset values and counts of the panel geometry block.
// assumes a 32-bit classic wishbone bus with one register per aligned word (byte address = index * 4).
package lcdgeo_pkg;

  // register indices, byte address is four times the index
  localparam logic [15:0] IDX_CHAR_WIDTH_AND_AC_MODE = 16'h8001;
  localparam logic [15:0] IDX_CHAR_HEIGHT = 16'h8002;
  localparam logic [15:0] IDX_VISIBLE_BYTES_PER_LINE = 16'h8003;
  localparam logic [15:0] IDX_TOTAL_BYTES_PER_LINE = 16'h8004;
  localparam logic [15:0] IDX_FRAME_LINE_COUNT = 16'h8005;
  localparam logic [15:0] IDX_VIRTUAL_PITCH_LOW = 16'h8006;
  localparam logic [15:0] IDX_VIRTUAL_PITCH_HIGH = 16'h8007;
  localparam logic [15:0] IDX_LOW_POWER_CONTROL = 16'h8008;

  // field positions
  localparam int AC_WAVEFORM_SELECT_BIT = 7;
  localparam int POWER_SAVE_BIT = 0;

  // reset values
  localparam logic [7:0] RST_GEOMETRY = 8'h00;
  localparam logic [7:0] RST_LOW_POWER_CONTROL = 8'h01;

  // writable bits, the rest read as zero
  localparam logic [7:0] MASK_CHAR_WIDTH_AND_AC_MODE = 8'h8f;
  localparam logic [7:0] MASK_CHAR_HEIGHT = 8'h0f;
  localparam logic [7:0] MASK_VIRTUAL_PITCH_HIGH = 8'h7f;
  localparam logic [7:0] MASK_LOW_POWER_CONTROL = 8'h01;

  // lines per half period of line-based ac drive, minus one
  localparam logic [3:0] AC_LINE_GROUP_LAST = 4'hf;
  // pixels per display byte
  localparam logic [4:0] BYTE_PIXELS = 5'h08;

endpackage

/* verilog/lcdgeo_core.sv */
// lcdgeo_core: geometry and power-save registers plus line, frame, cell and ac drive timing.
// assumes a classic wishbone master and neighbouring logic on the same clock that owns
// the memory configuration and display enable registers and the command decoder.
`timescale 1ns/1ns

module lcdgeo_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic indirect_mode_i,
  input wire logic mem_cfg_write_i,
  input wire logic power_save_cmd_i,
  input wire logic user_glyph_ram_i,
  input wire logic [1:0] bpp_request_i,
  output logic [1:0] bpp_effective_o,
  output logic osc_run_o,
  output logic power_save_o,
  output logic display_off_o,
  output logic line_pulse_o,
  output logic frame_pulse_o,
  output logic visible_o,
  output logic [7:0] byte_column_o,
  output logic [7:0] line_number_o,
  output logic [3:0] cell_row_o,
  output logic segment_o,
  output logic [7:0] pixel_mask_o,
  output logic ac_waveform_o,
  output logic [15:0] line_address_o,
  output logic [15:0] virtual_line_pitch_o
);

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [7:0] width_ac;
    logic [7:0] height;
    logic [7:0] visible;
    logic [7:0] total;
    logic [7:0] frame;
    logic [7:0] pitch_lo;
    logic [7:0] pitch_hi;
    logic ps_bit;
    logic ps_active;
    logic exit_pend;
    logic disp_off;
    logic line_p;
    logic frame_p;
    logic vis;
    logic [7:0] byte_cnt;
    logic [7:0] line_cnt;
    logic [3:0] row_cnt;
    logic [3:0] ac_cnt;
    logic ac;
    logic seg;
    logic [7:0] pix_mask;
    logic [15:0] line_addr;
  } lcdgeo_state_t;

  lcdgeo_state_t st_r;
  lcdgeo_state_t st_nxt;

  logic req;
  logic hit_word;
  logic [15:0] idx;
  logic wr_now;
  logic wr_lane;
  logic [7:0] wbyte;
  logic [4:0] cell_pixels;
  logic [4:0] seg_pixels;
  logic [15:0] pitch;
  logic line_end;
  logic frame_end;
  logic next_seg;

  // msb-first mask of n pixels, n from 0 to 8
  function automatic logic [7:0] lcdgeo_mask(input logic [4:0] n);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (5'(i) < n) begin
        m[7 - i] = 1'b1;
      end
    end
    return m;
  endfunction

  assign req = cyc_i & stb_i;
  assign idx = adr_i[17:2];
  assign hit_word = (adr_i[31:18] == 14'h0000) & (adr_i[1:0] == 2'h0);
  // write takes effect on the edge where the master samples ack high
  assign wr_now = req & we_i & st_r.ack;
  assign wr_lane = wr_now & hit_word & sel_i[0];
  assign wbyte = dat_i[7:0];
  assign pitch = {st_r.pitch_hi, st_r.pitch_lo};
  assign line_end = st_r.byte_cnt == st_r.total;
  assign frame_end = line_end & (st_r.line_cnt == st_r.frame);
  assign cell_pixels = {1'b0, st_r.width_ac[3:0]} + 5'h01;

  always_comb begin
    st_nxt = st_r;
    st_nxt.disp_off = 1'b0;
    st_nxt.line_p = 1'b0;
    st_nxt.frame_p = 1'b0;

    // bus slave: one-cycle ack, then dropped; unmapped reads give zero
    st_nxt.ack = req & ~st_r.ack;
    st_nxt.rdat = 8'h00;
    if (req & ~st_r.ack & ~we_i & hit_word) begin
      case (idx)
        lcdgeo_pkg::IDX_CHAR_WIDTH_AND_AC_MODE: st_nxt.rdat = st_r.width_ac;
        lcdgeo_pkg::IDX_CHAR_HEIGHT: st_nxt.rdat = st_r.height;
        lcdgeo_pkg::IDX_VISIBLE_BYTES_PER_LINE: st_nxt.rdat = st_r.visible;
        lcdgeo_pkg::IDX_TOTAL_BYTES_PER_LINE: st_nxt.rdat = st_r.total;
        lcdgeo_pkg::IDX_FRAME_LINE_COUNT: st_nxt.rdat = st_r.frame;
        lcdgeo_pkg::IDX_VIRTUAL_PITCH_LOW: st_nxt.rdat = st_r.pitch_lo;
        lcdgeo_pkg::IDX_VIRTUAL_PITCH_HIGH: st_nxt.rdat = st_r.pitch_hi;
        lcdgeo_pkg::IDX_LOW_POWER_CONTROL: st_nxt.rdat = {7'h00, st_r.ps_bit};
        default: st_nxt.rdat = 8'h00;
      endcase
    end

    // direct mode: any write after the clearing write, except one to the low power control register, finishes the exit
    if (wr_now & st_r.exit_pend & ~indirect_mode_i) begin
      st_nxt.ps_active = 1'b0;
      st_nxt.exit_pend = 1'b0;
    end

    if (wr_lane) begin
      case (idx)
        lcdgeo_pkg::IDX_CHAR_WIDTH_AND_AC_MODE: st_nxt.width_ac = wbyte & lcdgeo_pkg::MASK_CHAR_WIDTH_AND_AC_MODE;
        lcdgeo_pkg::IDX_CHAR_HEIGHT: st_nxt.height = wbyte & lcdgeo_pkg::MASK_CHAR_HEIGHT;
        lcdgeo_pkg::IDX_VISIBLE_BYTES_PER_LINE: st_nxt.visible = wbyte;
        lcdgeo_pkg::IDX_TOTAL_BYTES_PER_LINE: st_nxt.total = wbyte;
        lcdgeo_pkg::IDX_FRAME_LINE_COUNT: st_nxt.frame = wbyte;
        lcdgeo_pkg::IDX_VIRTUAL_PITCH_LOW: st_nxt.pitch_lo = wbyte;
        lcdgeo_pkg::IDX_VIRTUAL_PITCH_HIGH: st_nxt.pitch_hi = wbyte & lcdgeo_pkg::MASK_VIRTUAL_PITCH_HIGH;
        lcdgeo_pkg::IDX_LOW_POWER_CONTROL: begin
          st_nxt.ps_bit = wbyte[lcdgeo_pkg::POWER_SAVE_BIT];
          if (wbyte[lcdgeo_pkg::POWER_SAVE_BIT]) begin
            st_nxt.ps_active = 1'b1;
            st_nxt.exit_pend = 1'b0;
            st_nxt.disp_off = ~st_r.ps_active;
          end else if (st_r.ps_active & ~indirect_mode_i) begin
            st_nxt.ps_active = 1'b1;
            st_nxt.exit_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // indirect command entry
    if (power_save_cmd_i & indirect_mode_i) begin
      st_nxt.ps_bit = 1'b1;
      st_nxt.ps_active = 1'b1;
      st_nxt.exit_pend = 1'b0;
      st_nxt.disp_off = ~st_r.ps_active;
    end

    // free-running scan, halted in power save
    if (~st_r.ps_active) begin
      st_nxt.byte_cnt = st_r.byte_cnt + 8'h01;
      next_seg = st_r.width_ac[3] & ~st_r.seg;
      if (line_end) begin
        st_nxt.byte_cnt = 8'h00;
        next_seg = 1'b0;
        st_nxt.line_p = 1'b1;
        st_nxt.line_cnt = st_r.line_cnt + 8'h01;
        st_nxt.line_addr = st_r.line_addr + pitch;
        st_nxt.row_cnt = (st_r.row_cnt == st_r.height[3:0]) ? 4'h0 : st_r.row_cnt + 4'h1;
        st_nxt.ac_cnt = st_r.ac_cnt + 4'h1;
        if (~st_r.width_ac[lcdgeo_pkg::AC_WAVEFORM_SELECT_BIT]
            & (st_r.ac_cnt == lcdgeo_pkg::AC_LINE_GROUP_LAST)) begin
          st_nxt.ac = ~st_r.ac;
        end
        if (frame_end) begin
          st_nxt.line_cnt = 8'h00;
          st_nxt.line_addr = 16'h0000;
          st_nxt.row_cnt = 4'h0;
          st_nxt.frame_p = 1'b1;
          if (st_r.width_ac[lcdgeo_pkg::AC_WAVEFORM_SELECT_BIT]) begin
            st_nxt.ac = ~st_r.ac;
          end
        end
      end
      st_nxt.seg = next_seg;
      st_nxt.vis = st_nxt.byte_cnt <= st_r.visible;
      // pixels shown in the coming byte: width minus one plus one, split in 8-pixel parts
      seg_pixels = next_seg ? cell_pixels - lcdgeo_pkg::BYTE_PIXELS
                 : ((cell_pixels > lcdgeo_pkg::BYTE_PIXELS) ? lcdgeo_pkg::BYTE_PIXELS : cell_pixels);
      st_nxt.pix_mask = st_nxt.vis ? lcdgeo_mask(seg_pixels) : 8'h00;
    end else begin
      next_seg = st_r.seg;
      seg_pixels = 5'h00;
    end

    // memory configuration write or system configuration command
    if (mem_cfg_write_i) begin
      st_nxt.byte_cnt = 8'h00;
      st_nxt.line_cnt = 8'h00;
      st_nxt.row_cnt = 4'h0;
      st_nxt.ac_cnt = 4'h0;
      st_nxt.seg = 1'b0;
      st_nxt.vis = 1'b0;
      st_nxt.pix_mask = 8'h00;
      st_nxt.line_addr = 16'h0000;
      st_nxt.line_p = 1'b0;
      st_nxt.frame_p = 1'b0;
      st_nxt.disp_off = 1'b1;
      if (indirect_mode_i) begin
        st_nxt.ps_bit = 1'b0;
        st_nxt.ps_active = 1'b0;
        st_nxt.exit_pend = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.width_ac <= lcdgeo_pkg::RST_GEOMETRY;
      st_r.height <= lcdgeo_pkg::RST_GEOMETRY;
      st_r.visible <= lcdgeo_pkg::RST_GEOMETRY;
      st_r.total <= lcdgeo_pkg::RST_GEOMETRY;
      st_r.frame <= lcdgeo_pkg::RST_GEOMETRY;
      st_r.pitch_lo <= lcdgeo_pkg::RST_GEOMETRY;
      st_r.pitch_hi <= lcdgeo_pkg::RST_GEOMETRY;
      st_r.ps_bit <= lcdgeo_pkg::RST_LOW_POWER_CONTROL[lcdgeo_pkg::POWER_SAVE_BIT];
      st_r.ps_active <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ack_o = st_r.ack;
  assign dat_o = {24'h000000, st_r.rdat};
  assign osc_run_o = ~st_r.ps_active;
  assign power_save_o = st_r.ps_active;
  assign display_off_o = st_r.disp_off;
  assign line_pulse_o = st_r.line_p;
  assign frame_pulse_o = st_r.frame_p;
  assign visible_o = st_r.vis;
  assign byte_column_o = st_r.byte_cnt;
  assign line_number_o = st_r.line_cnt;
  assign cell_row_o = st_r.row_cnt;
  assign segment_o = st_r.seg;
  assign pixel_mask_o = st_r.pix_mask;
  assign ac_waveform_o = st_r.ac;
  assign line_address_o = st_r.line_addr;
  assign virtual_line_pitch_o = pitch;
  assign bpp_effective_o = user_glyph_ram_i ? 2'h0 : bpp_request_i;

endmodule // lcdgeo_core

/* test/lcdgeo_host.sv */
// lcdgeo_host: classic wishbone master standing in for the host processor.
// assumes the slave acks each request; the bench bounds every wait.
`timescale 1ns/1ns
module lcdgeo_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [31:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end

  // one cycle, held until ack; a fresh call leaves the bus idle one cycle
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, 14'h0000, idx, 2'b00, 4'hf, 24'h000000, wd};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rd = dat_i[7:0];
    {cyc_o, stb_o, we_o} <= 3'b000;
  endtask
endmodule // lcdgeo_host

/* test/lcdgeo_checker.sv */
// lcdgeo_checker: port-level properties of the panel geometry block.
// assumes single clock domain and synchronous active-high reset.
`timescale 1ns/1ns
module lcdgeo_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic mem_cfg_write_i,
  input wire logic user_glyph_ram_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [1:0] bpp_effective_o,
  input wire logic osc_run_o,
  input wire logic power_save_o,
  input wire logic display_off_o,
  input wire logic line_pulse_o,
  input wire logic frame_pulse_o,
  input wire logic [7:0] byte_column_o,
  input wire logic [7:0] line_number_o,
  input wire logic [15:0] virtual_line_pitch_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("data without ack");
  a_osc_follows_save: assert property (osc_run_o == !power_save_o) else $error("osc state");
  a_halt_freeze: assert property (power_save_o ##1 (power_save_o && !$past(mem_cfg_write_i))
    |-> $stable(byte_column_o)) else $error("counting while halted");
  a_line_wrap: assert property (line_pulse_o |-> byte_column_o == 8'h00) else $error("line wrap");
  a_frame_with_line: assert property (frame_pulse_o |-> line_pulse_o && line_number_o == 8'h00)
    else $error("frame pulse");
  a_cfg_blanks: assert property (mem_cfg_write_i |=> display_off_o) else $error("no blank");
  a_glyph_one_bpp: assert property (user_glyph_ram_i |-> bpp_effective_o == 2'b00) else $error("bpp");
  a_pitch_top: assert property (virtual_line_pitch_o[15] == 1'b0) else $error("pitch bit15");
  c_frame: cover property (frame_pulse_o);
  c_blank_save: cover property (display_off_o && power_save_o);
  c_wake: cover property ($fell(power_save_o));
endmodule // lcdgeo_checker

bind lcdgeo_core lcdgeo_checker chk (.clk_i, .rst_i, .cyc_i, .stb_i, .mem_cfg_write_i, .user_glyph_ram_i,
  .dat_o, .ack_o, .bpp_effective_o, .osc_run_o, .power_save_o, .display_off_o, .line_pulse_o,
  .frame_pulse_o, .byte_column_o, .line_number_o, .virtual_line_pitch_o);

/* test/testbench.sv */
// testbench: directed tests of registers, power save, scan timing and ac drive.
// assumes lcdgeo_host as bus master and the bound checker.
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i, stb_i, we_i, ack_o, indirect_mode_i, mem_cfg_write_i, power_save_cmd_i, user_glyph_ram_i;
  logic osc_run_o, power_save_o, display_off_o, line_pulse_o, frame_pulse_o, segment_o, ac_waveform_o, visible_o;
  logic seg_hit, d;
  logic [1:0] bpp_request_i, bpp_effective_o;
  logic [3:0] sel_i, cell_row_o, crow;
  logic [7:0] byte_column_o, line_number_o, pixel_mask_o, rd;
  logic [7:0] msk [8] = '{8'h00, 8'h8f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f};
  logic [15:0] line_address_o, virtual_line_pitch_o;
  logic [31:0] adr_i, dat_i, dat_o;
  int bad_count, num_checks, n, lines;
  always #5 clk_i = ~clk_i;
  lcdgeo_core uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .indirect_mode_i,
    .mem_cfg_write_i, .power_save_cmd_i, .user_glyph_ram_i, .bpp_request_i, .bpp_effective_o, .osc_run_o,
    .power_save_o, .display_off_o, .line_pulse_o, .frame_pulse_o, .visible_o, .byte_column_o, .line_number_o,
    .cell_row_o, .segment_o, .pixel_mask_o, .ac_waveform_o, .line_address_o, .virtual_line_pitch_o);
  lcdgeo_host host (.clk_i, .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
    .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    host.xfer(1'b1, idx, v, rd);
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [7:0] v);
    host.xfer(1'b0, idx, 8'h00, rd);
    `CHK(rd, v)
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic pulse(input logic ps);
    @(posedge clk_i);
    if (ps) power_save_cmd_i <= 1'b1;
    else mem_cfg_write_i <= 1'b1;
    @(posedge clk_i);
    {power_save_cmd_i, mem_cfg_write_i} <= 2'b00;
    #1;
  endtask
  task automatic t_regs();
    for (int i = 1; i <= 8; i++) rchk(16'h8000 + 16'(i), (i == 8) ? 8'h01 : 8'h00);
    for (int i = 1; i <= 7; i++) wr(16'h8000 + 16'(i), 8'hff);
    for (int i = 1; i <= 7; i++) rchk(16'h8000 + 16'(i), msk[i]);
    `CHK(virtual_line_pitch_o, 16'h7fff)
    rchk(16'h8010, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_direct();
    wr(16'h8008, 8'hfe);
    rchk(16'h8008, 8'h00);
    `CHK(power_save_o, 1'b1)
    wr(16'h8010, 8'h00);
    #1 `CHK(osc_run_o, 1'b1)
    $display("t_direct done");
  endtask
  task automatic frame_len();
    for (n = 0; frame_pulse_o !== 1'b1 && n < 5000; n++) step();
    {n, lines, crow, seg_hit} = '0;
    do begin
      step();
      n++;
      lines += int'(line_pulse_o === 1'b1);
      if (cell_row_o > crow) crow = cell_row_o;
      if (segment_o === 1'b1 && visible_o === 1'b1 && pixel_mask_o === 8'h80) seg_hit = 1'b1;
    end while (frame_pulse_o !== 1'b1 && n < 5000);
  endtask
  task automatic t_timing();
    wr(16'h8001, 8'h08);
    wr(16'h8002, 8'h02);
    wr(16'h8003, 8'h03);
    wr(16'h8004, 8'h05);
    wr(16'h8005, 8'h07);
    pulse(1'b0);
    `CHK(display_off_o, 1'b1)
    frame_len();
    `CHK(n, 48)
    `CHK(lines, 8)
    `CHK(crow, 4'h2)
    `CHK(seg_hit, 1'b1)
    repeat (6) step();
    `CHK(line_number_o, 8'h01)
    `CHK(line_address_o, 16'h7fff)
    $display("t_timing done");
  endtask
  task automatic ac_gap();
    logic a;
    for (int r = 0; r < 2; r++) begin
      a = ac_waveform_o;
      for (n = 0; ac_waveform_o === a && n < 5000; n++) step();
    end
  endtask
  task automatic t_ac();
    wr(16'h8001, 8'h88);
    ac_gap();
    `CHK(n, 48)
    wr(16'h8001, 8'h08);
    wr(16'h8005, 8'h3f);
    ac_gap();
    `CHK(n, 96)
    $display("t_ac done");
  endtask
  task automatic t_indirect();
    indirect_mode_i <= 1'b1;
    pulse(1'b1);
    d = display_off_o;
    step();
    `CHK(d | display_off_o, 1'b1)
    `CHK(power_save_o, 1'b1)
    wr(16'h8008, 8'h00);
    wr(16'h8010, 8'h00);
    #1 `CHK(power_save_o, 1'b1)
    pulse(1'b0);
    `CHK(power_save_o, 1'b0)
    {user_glyph_ram_i, bpp_request_i} <= 3'b111;
    step();
    `CHK(bpp_effective_o, 2'b00)
    user_glyph_ram_i <= 1'b0;
    step();
    `CHK(bpp_effective_o, 2'b11)
    $display("t_indirect done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    bad_count++;
    end_of_test();
  end
  initial begin
    {indirect_mode_i, mem_cfg_write_i, power_save_cmd_i, user_glyph_ram_i, bpp_request_i} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_direct();
    t_timing();
    t_ac();
    t_indirect();
    end_of_test();
  end
endmodule // testbench
